// file: shared/osc_ctrl_pkg.sv
// constants for the oscillator select control block
package osc_ctrl_pkg;
	localparam logic [7:0] general_offset = 8'h00;
	localparam logic [7:0] internal_offset = 8'h01;
	localparam logic [7:0] crystal_offset = 8'h02;
	localparam int source_sel_bit = 0;
	localparam int tile_reset_en_bit = 1;
	localparam int int_enable_bit = 0;
	localparam int int_slow_bit = 1;
	localparam int xtal_enable_bit = 0;
	localparam int xtal_bias_bit = 1;
	localparam logic tile_reset_en_reset = 1'b0;
	localparam logic int_slow_reset = 1'b0;
	localparam logic int_enable_reset = 1'b1;
	localparam logic xtal_bias_reset = 1'b1;
	localparam logic xtal_enable_reset = 1'b1;
	localparam logic [7:0] access_size_byte = 8'h01;
	localparam logic [1:0] tile_reset_cycles = 2'h3;
	localparam logic [1:0] strap_settle_cycles = 2'h3;
endpackage : osc_ctrl_pkg

// file: src/oscillator_select_control.sv
// oscillator select control registers and outputs
`timescale 1ns/1ps
module oscillator_select_control (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic source_strap,
	input wire logic periph_sel,
	input wire logic periph_write,
	input wire logic [7:0] periph_size,
	input wire logic [7:0] periph_addr,
	input wire logic [7:0] periph_wdata,
	output logic [7:0] periph_rdata,
	output logic periph_ack,
	output logic periph_err,
	output logic source_internal,
	output logic internal_osc_enable,
	output logic internal_osc_slow,
	output logic crystal_osc_enable,
	output logic crystal_bias_enable,
	output logic tile_reset
);
	logic [2:0] strap_sync;
	logic strap_loaded;
	logic [1:0] strap_fill;
	logic tile_reset_en;
	logic [1:0] reset_count;
	logic byte_access;
	logic addr_hit;
	logic wr_general;
	logic wr_internal;
	logic wr_crystal;
	logic next_source;
	logic source_change;
	logic [7:0] next_rdata;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			strap_sync <= 3'h0;
		end else begin
			strap_sync <= {strap_sync[1:0], source_strap};
		end
	end

	// stages hold reset zeros until three pin samples have passed
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			strap_fill <= 2'h0;
		end else if (strap_fill != osc_ctrl_pkg::strap_settle_cycles) begin
			strap_fill <= strap_fill + 2'h1;
		end
	end

	assign byte_access = periph_size == osc_ctrl_pkg::access_size_byte;
	assign addr_hit = periph_addr == osc_ctrl_pkg::general_offset ||
		periph_addr == osc_ctrl_pkg::internal_offset ||
		periph_addr == osc_ctrl_pkg::crystal_offset;
	assign wr_general = periph_sel && periph_write && byte_access &&
		periph_addr == osc_ctrl_pkg::general_offset;
	assign wr_internal = periph_sel && periph_write && byte_access &&
		periph_addr == osc_ctrl_pkg::internal_offset;
	assign wr_crystal = periph_sel && periph_write && byte_access &&
		periph_addr == osc_ctrl_pkg::crystal_offset;
	assign next_source = periph_wdata[osc_ctrl_pkg::source_sel_bit];
	assign source_change = wr_general && strap_loaded &&
		next_source != source_internal;

	// strap caught once the synchroniser has settled after release
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			strap_loaded <= 1'b0;
			source_internal <= 1'b0;
		end else if (!strap_loaded) begin
			if (strap_fill == osc_ctrl_pkg::strap_settle_cycles &&
				strap_sync[1] == strap_sync[2]) begin
				strap_loaded <= 1'b1;
				source_internal <= strap_sync[2];
			end
		end else if (wr_general) begin
			source_internal <= next_source;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			tile_reset_en <= osc_ctrl_pkg::tile_reset_en_reset;
		end else if (wr_general) begin
			tile_reset_en <= periph_wdata[osc_ctrl_pkg::tile_reset_en_bit];
		end
	end

	// tile reset pulse on a source change, held a few cycles
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			reset_count <= 2'h0;
			tile_reset <= 1'b0;
		end else if (source_change && tile_reset_en) begin
			reset_count <= osc_ctrl_pkg::tile_reset_cycles;
			tile_reset <= 1'b1;
		end else if (reset_count != 2'h0) begin
			reset_count <= reset_count - 2'h1;
			tile_reset <= reset_count != 2'h1;
		end else begin
			tile_reset <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			internal_osc_enable <= osc_ctrl_pkg::int_enable_reset;
			internal_osc_slow <= osc_ctrl_pkg::int_slow_reset;
		end else if (wr_internal) begin
			internal_osc_enable <= periph_wdata[osc_ctrl_pkg::int_enable_bit];
			internal_osc_slow <= periph_wdata[osc_ctrl_pkg::int_slow_bit];
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			crystal_osc_enable <= osc_ctrl_pkg::xtal_enable_reset;
			crystal_bias_enable <= osc_ctrl_pkg::xtal_bias_reset;
		end else if (wr_crystal) begin
			crystal_osc_enable <= periph_wdata[osc_ctrl_pkg::xtal_enable_bit];
			crystal_bias_enable <= periph_wdata[osc_ctrl_pkg::xtal_bias_bit];
		end
	end

	always_comb begin
		next_rdata = 8'h00;
		case (periph_addr)
			osc_ctrl_pkg::general_offset: begin
				next_rdata[osc_ctrl_pkg::source_sel_bit] = source_internal;
				next_rdata[osc_ctrl_pkg::tile_reset_en_bit] = tile_reset_en;
			end
			osc_ctrl_pkg::internal_offset: begin
				next_rdata[osc_ctrl_pkg::int_enable_bit] = internal_osc_enable;
				next_rdata[osc_ctrl_pkg::int_slow_bit] = internal_osc_slow;
			end
			osc_ctrl_pkg::crystal_offset: begin
				next_rdata[osc_ctrl_pkg::xtal_enable_bit] = crystal_osc_enable;
				next_rdata[osc_ctrl_pkg::xtal_bias_bit] = crystal_bias_enable;
			end
			default: begin
				next_rdata = 8'h00;
			end
		endcase
	end

	// one-cycle answer to every selected access
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			periph_ack <= 1'b0;
			periph_err <= 1'b0;
			periph_rdata <= 8'h00;
		end else begin
			periph_ack <= periph_sel;
			periph_err <= periph_sel && !(byte_access && addr_hit);
			if (periph_sel && !periph_write && byte_access && addr_hit) begin
				periph_rdata <= next_rdata;
			end else begin
				periph_rdata <= 8'h00;
			end
		end
	end

	// once the strap is loaded, source only moves on a general register write
	source_hold_a: assert property (@(posedge mclk)
		disable iff (!rst_b)
		$past(strap_loaded) && !$past(wr_general) |->
		$stable(source_internal))
		else $error("source changed without a write");
	strap_load_a: assert property (@(posedge mclk)
		disable iff (!rst_b)
		!strap_loaded && strap_fill == osc_ctrl_pkg::strap_settle_cycles &&
		strap_sync[1] == strap_sync[2] |=>
		strap_loaded && source_internal == $past(strap_sync[2]))
		else $error("strap level not loaded");
	read_general_a: assert property (@(posedge mclk)
		disable iff (!rst_b)
		periph_sel && !periph_write && byte_access &&
		periph_addr == osc_ctrl_pkg::general_offset |=>
		periph_rdata[1:0] == {$past(tile_reset_en), $past(source_internal)})
		else $error("general register read wrong");
	// a change during a pulse restarts it, so the tail may stay high
	tile_pulse_a: assert property (@(posedge mclk)
		disable iff (!rst_b)
		source_change && tile_reset_en |=>
		tile_reset [*3] ##1 (!tile_reset || reset_count != 2'h0))
		else $error("tile reset pulse length wrong");
	tile_quiet_a: assert property (@(posedge mclk)
		disable iff (!rst_b)
		source_change && !tile_reset_en && reset_count == 2'h0 |=>
		!tile_reset)
		else $error("tile reset without enable");
	int_write_a: assert property (@(posedge mclk)
		disable iff (!rst_b)
		wr_internal |=> internal_osc_slow == $past(periph_wdata[1]) &&
		internal_osc_enable == $past(periph_wdata[0]))
		else $error("internal oscillator write lost");
	rate_hold_a: assert property (@(posedge mclk)
		disable iff (!rst_b)
		!wr_internal && !wr_crystal |=> $stable(internal_osc_slow) &&
		$stable(crystal_bias_enable))
		else $error("rate or bias changed without a write");
	xtal_write_a: assert property (@(posedge mclk)
		disable iff (!rst_b)
		wr_crystal |=> crystal_bias_enable == $past(periph_wdata[1]) &&
		crystal_osc_enable == $past(periph_wdata[0]))
		else $error("crystal write lost");
	xtal_hold_a: assert property (@(posedge mclk)
		disable iff (!rst_b)
		!wr_crystal && !wr_internal |=> $stable(crystal_osc_enable) &&
		$stable(internal_osc_enable))
		else $error("enable changed without a write");
	wide_refused_a: assert property (@(posedge mclk)
		disable iff (!rst_b)
		periph_sel && !byte_access |=> periph_err && periph_rdata == 8'h00)
		else $error("non-byte access not refused");
	ack_answer_a: assert property (@(posedge mclk)
		disable iff (!rst_b)
		periph_sel |=> periph_ack)
		else $error("access not answered");
	ack_idle_a: assert property (@(posedge mclk)
		disable iff (!rst_b)
		!periph_sel |=> !periph_ack && !periph_err)
		else $error("answer without access");
	reserved_zero_a: assert property (@(posedge mclk)
		disable iff (!rst_b)
		periph_ack |-> periph_rdata[7:2] == 6'h00)
		else $error("reserved bits read nonzero");

	source_switch_c: cover property (@(posedge mclk) disable iff (!rst_b)
		source_change && tile_reset_en);
	slow_rate_c: cover property (@(posedge mclk) disable iff (!rst_b)
		wr_internal && periph_wdata[1]);
	bias_off_c: cover property (@(posedge mclk) disable iff (!rst_b)
		wr_crystal && !periph_wdata[1]);
	strap_high_c: cover property (@(posedge mclk) disable iff (!rst_b)
		$rose(strap_loaded) && source_internal);
	unmapped_c: cover property (@(posedge mclk) disable iff (!rst_b)
		periph_sel && byte_access && !addr_hit);
endmodule : oscillator_select_control

// file: testbench/tb.sv
// self-checking bench for the oscillator select control block
`timescale 1ns/1ps
module tb;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic source_strap = 1'b1;
	logic periph_sel = 1'b0;
	logic periph_write = 1'b0;
	logic [7:0] periph_size = 8'h01;
	logic [7:0] periph_addr = 8'h00;
	logic [7:0] periph_wdata = 8'h00;
	logic [7:0] periph_rdata;
	logic periph_ack, periph_err, source_internal, tile_reset;
	logic internal_osc_enable, internal_osc_slow;
	logic crystal_osc_enable, crystal_bias_enable;
	logic [15:0] lfsr = 16'hd43b;
	logic [7:0] m [0:2];
	logic [7:0] wd;
	int fails = 0;
	int n_tests = 0;
	int cycles = 0;
	oscillator_select_control u_dut (.mclk(mclk), .rst_b(rst_b),
		.source_strap(source_strap), .periph_sel(periph_sel),
		.periph_write(periph_write), .periph_size(periph_size),
		.periph_addr(periph_addr), .periph_wdata(periph_wdata),
		.periph_rdata(periph_rdata), .periph_ack(periph_ack),
		.periph_err(periph_err), .source_internal(source_internal),
		.internal_osc_enable(internal_osc_enable),
		.internal_osc_slow(internal_osc_slow),
		.crystal_osc_enable(crystal_osc_enable),
		.crystal_bias_enable(crystal_bias_enable), .tile_reset(tile_reset));
	initial begin
		forever #2 mclk = ~mclk;
	end
	function automatic logic [15:0] next_rand(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : next_rand
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_sim
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fails++;
			end_sim();
		end
	end
	task automatic check(input string name, input logic [7:0] exp,
		input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", name, exp, got);
			fails++;
		end
	endtask : check
	// one access, answer checked in the ack cycle
	task automatic access(input logic w, input logic [7:0] sz, a, wd, rd,
		input logic er);
		@(posedge mclk);
		periph_sel <= 1'b1;
		periph_write <= w;
		periph_size <= sz;
		periph_addr <= a;
		periph_wdata <= wd;
		@(posedge mclk);
		periph_sel <= 1'b0;
		#1;
		check("ack", 8'h01, {7'h00, periph_ack});
		check("err", {7'h00, er}, {7'h00, periph_err});
		if (!w) check("rdata", rd, periph_rdata);
	endtask : access
	task automatic outs;
		check("outs", {3'h0, m[0][0], m[1][1:0], m[2][1:0]},
			{3'h0, source_internal, internal_osc_slow, internal_osc_enable,
			crystal_bias_enable, crystal_osc_enable});
	endtask : outs
	// reset with a given strap level, then check every reset value
	task automatic reset_run(input logic strap);
		@(posedge mclk);
		source_strap <= strap;
		rst_b <= 1'b0;
		repeat (12) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (4) @(posedge mclk);
		m[0] = {7'h00, strap};
		m[1] = 8'h01;
		m[2] = 8'h03;
		for (int i = 0; i < 3; i++) begin
			access(1'b0, 8'h01, 8'(i), 8'h00, m[i], 1'b0);
		end
		outs();
		check("tile reset idle", 8'h00, {7'h00, tile_reset});
	endtask : reset_run
	initial begin
		reset_run(1'b1);
		$display("test reset values done");
		access(1'b1, 8'h01, 8'h00, 8'h02, 8'h00, 1'b0);
		m[0] = 8'h02;
		check("no tile reset", 8'h00, {7'h00, tile_reset});
		access(1'b1, 8'h01, 8'h00, 8'hff, 8'h00, 1'b0);
		m[0] = 8'h03;
		outs();
		for (int i = 0; i < 4; i++) begin
			check("tile reset", {7'h00, i < 3}, {7'h00, tile_reset});
			@(posedge mclk);
			#1;
		end
		access(1'b1, 8'h01, 8'h00, 8'h03, 8'h00, 1'b0);
		check("same source", 8'h00, {7'h00, tile_reset});
		access(1'b0, 8'h01, 8'h00, 8'h00, m[0], 1'b0);
		$display("test tile reset done");
		access(1'b1, 8'h02, 8'h01, 8'h00, 8'h00, 1'b1);
		access(1'b0, 8'h04, 8'h01, 8'h00, 8'h00, 1'b1);
		access(1'b0, 8'h01, 8'h03, 8'h00, 8'h00, 1'b1);
		access(1'b0, 8'h01, 8'h01, 8'h00, m[1], 1'b0);
		$display("test refused access done");
		for (int i = 0; i < 24; i++) begin
			lfsr = next_rand(lfsr);
			wd = lfsr[7:0] | {7'h00, !lfsr[8]};
			access(1'b1, 8'h01, {7'h00, lfsr[8]} + 8'h01, wd, 8'h00,
				1'b0);
			m[lfsr[8] + 1] = wd & 8'h03;
			outs();
			access(1'b0, 8'h01, {7'h00, lfsr[8]} + 8'h01, 8'h00,
				m[lfsr[8] + 1], 1'b0);
		end
		$display("test random settings done");
		reset_run(1'b0);
		$display("test strap low reset done");
		end_sim();
	end
endmodule : tb
